// File: pkg/xcpc_pkg.sv
// constants shared by the transceiver common port layer
package xcpc_pkg;

  localparam int LANES          = 4;
  localparam int DATA_W         = 80;
  localparam int FIFO_DEPTH     = 16;
  localparam int ADDR_W         = 4;

  localparam logic [ADDR_W-1:0] CTRL_OFFS   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 4'h4;
  localparam logic [ADDR_W-1:0] RXCNT_OFFS  = 4'h8;

  localparam int CTRL_PMA_DIRECT_BIT = 0;
  localparam int CTRL_TX_EN_BIT      = 1;
  localparam int CTRL_RX_EN_BIT      = 2;
  localparam int CTRL_EXT_PLL_BIT    = 3;
  localparam int CTRL_W              = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  localparam int STAT_PLL_LOCK_BIT = 0;
  localparam int STAT_TXA_POS      = 4;
  localparam int STAT_TXD_POS      = 8;
  localparam int STAT_RXA_POS      = 12;
  localparam int STAT_RXD_POS      = 16;
  localparam int STAT_LEVEL_POS    = 20;

  localparam int CLK_PERIOD_NS   = 10;
  localparam int RST_HOLD_NS     = 100;
  localparam int RST_HOLD_CYC    = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 4;
  localparam int PLL_LOCK_EDGES  = 8;
  localparam int BIT_CNT_W       = 7;
  localparam int WORD_HALF       = DATA_W / 2;

endpackage

// File: rtl/xcpc_fifo.sv
// word fifo with a registered read stage
`timescale 1ns/10ps
`default_nettype none
module xcpc_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = 16
) (
  input  wire logic             clock_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out,
  output logic [$clog2(DEPTH):0] level_out
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wptr_q;
  logic [PW-1:0]    rptr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready_out = (count_q != DEPTH[PW:0]);
  assign push         = in_valid_in && in_ready_out;
  // move a word into the output stage when it is empty or being drained
  assign pop          = (count_q != '0) && (!out_valid_out || out_ready_in);
  assign level_out    = count_q;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_q[wptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (pop) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem_q[rptr_q];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: rtl/xcpc_common.sv
// transceiver common port layer: resets, parallel clocks and pma-direct data
//
// Notes on behaviour
// - pll power-down rising edge resets tx pll
// - tx analog reset resets pma, clocking, serializer
// - lane 0 tx analog reset covers all lanes
// - tx digital reset clears lane tx datapath
// - rx analog reset clears cdr and deserializer
// - rx digital reset clears lane rx datapath
// - 80-bit tx words used only in pma-direct
// - 80-bit rx words delivered from deserializer
// - tx parallel clock only in pma-direct mode
// - each lane outputs its recovered rx clock
// - all ports exist even for disabled blocks
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module xcpc_common
  import xcpc_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic [31:0]            reg_rdata_out,
  // resets from fabric
  input  wire logic              pll_powerdown_in,
  input  wire logic [LANES-1:0]  tx_analog_reset_in,
  input  wire logic [LANES-1:0]  tx_digital_reset_in,
  input  wire logic [LANES-1:0]  rx_analog_reset_in,
  input  wire logic [LANES-1:0]  rx_digital_reset_in,
  // clocks
  input  wire logic              tx_pll_refclk_in,
  input  wire logic [LANES-1:0]  rx_cdr_refclk_in,
  input  wire logic              ext_pll_clk_in,
  output logic                   tx_pma_clkout_out,
  output logic [LANES-1:0]       rx_pma_clkout_out,
  output logic                   pll_locked_out,
  // pma-direct parallel data
  input  wire logic              tx_valid_in,
  output logic                   tx_ready_out,
  input  wire logic [DATA_W-1:0] tx_pma_parallel_data_in,
  output logic [DATA_W-1:0]      rx_pma_parallel_data_out,
  output logic                   rx_valid_out,
  // serial line
  output logic                   tx_serial_out,
  input  wire logic              rx_serial_in
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = 4 + 5 * LANES;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] sync_q;
  logic [PIN_W-1:0] prev_q;

  assign pin_raw = {rx_cdr_refclk_in, rx_digital_reset_in, rx_analog_reset_in,
                    tx_digital_reset_in, tx_analog_reset_in, ext_pll_clk_in,
                    tx_pll_refclk_in, rx_serial_in, pll_powerdown_in};

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  function automatic logic [LANES-1:0] rise(input logic [LANES-1:0] now,
                                            input logic [LANES-1:0] was);
    rise = now & ~was;
  endfunction

  logic             pd_rise;
  logic             rx_bit;
  logic             ref_rise;
  logic             ext_rise;
  logic [LANES-1:0] txa_rise;
  logic [LANES-1:0] txd_rise;
  logic [LANES-1:0] rxa_rise;
  logic [LANES-1:0] rxd_rise;
  logic [LANES-1:0] cdr_rise;

  assign pd_rise  = sync_q[0] & ~prev_q[0];
  assign rx_bit   = sync_q[1];
  assign ref_rise = sync_q[2] & ~prev_q[2];
  assign ext_rise = sync_q[3] & ~prev_q[3];
  assign txa_rise = rise(sync_q[4+:LANES], prev_q[4+:LANES]);
  assign txd_rise = rise(sync_q[4+LANES+:LANES], prev_q[4+LANES+:LANES]);
  assign rxa_rise = rise(sync_q[4+2*LANES+:LANES], prev_q[4+2*LANES+:LANES]);
  assign rxd_rise = rise(sync_q[4+3*LANES+:LANES], prev_q[4+3*LANES+:LANES]);
  assign cdr_rise = rise(sync_q[4+4*LANES+:LANES], prev_q[4+4*LANES+:LANES]);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic              pma_direct;
  logic              tx_en;
  logic              rx_en;
  logic              use_ext_pll;

  // every port stays present; blocks are switched by the control bits
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_write_in && reg_addr_in == CTRL_OFFS) begin
      ctrl_q <= reg_wdata_in[CTRL_W-1:0];
    end
  end

  assign pma_direct  = ctrl_q[CTRL_PMA_DIRECT_BIT];
  assign tx_en       = ctrl_q[CTRL_TX_EN_BIT];
  assign rx_en       = ctrl_q[CTRL_RX_EN_BIT];
  assign use_ext_pll = ctrl_q[CTRL_EXT_PLL_BIT];

  // ----------------------------------------------------------------
  // edge-triggered reset hold counters
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] HOLD = CNT_W'(RST_HOLD_CYC);
  localparam logic [CNT_W-1:0] LOCK = CNT_W'(PLL_LOCK_EDGES);

  logic [CNT_W-1:0]            pll_hold_q;
  logic [CNT_W-1:0]            lock_cnt_q;
  logic [LANES-1:0][CNT_W-1:0] txa_cnt_q;
  logic [LANES-1:0][CNT_W-1:0] txd_cnt_q;
  logic [LANES-1:0][CNT_W-1:0] rxa_cnt_q;
  logic [LANES-1:0][CNT_W-1:0] rxd_cnt_q;
  logic [LANES-1:0]            txa_rst;
  logic [LANES-1:0]            txd_rst;
  logic [LANES-1:0]            rxa_rst;
  logic [LANES-1:0]            rxd_rst;

  function automatic logic [CNT_W-1:0] hold_next(input logic trig,
                                                 input logic [CNT_W-1:0] cnt);
    if (trig) begin
      hold_next = HOLD;
    end else if (cnt != '0) begin
      hold_next = cnt - 1'b1;
    end else begin
      hold_next = cnt;
    end
  endfunction

  // pll is reset on a power-down edge and relocks after reference edges
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      pll_hold_q <= '0;
      lock_cnt_q <= '0;
    end else begin
      pll_hold_q <= hold_next(pd_rise, pll_hold_q);
      if (pd_rise || pll_hold_q != '0) begin
        lock_cnt_q <= '0;
      end else if (ref_rise && lock_cnt_q != LOCK) begin
        lock_cnt_q <= lock_cnt_q + 1'b1;
      end
    end
  end

  assign pll_locked_out = (lock_cnt_q == LOCK);

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      txa_cnt_q <= '0;
      txd_cnt_q <= '0;
      rxa_cnt_q <= '0;
      rxd_cnt_q <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        txa_cnt_q[i] <= hold_next(txa_rise[0], txa_cnt_q[i]);
        txd_cnt_q[i] <= hold_next(txd_rise[i], txd_cnt_q[i]);
        rxa_cnt_q[i] <= hold_next(rxa_rise[i], rxa_cnt_q[i]);
        rxd_cnt_q[i] <= hold_next(rxd_rise[i], rxd_cnt_q[i]);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      txa_rst[i] = (txa_cnt_q[i] != '0);
      txd_rst[i] = (txd_cnt_q[i] != '0);
      rxa_rst[i] = (rxa_cnt_q[i] != '0);
      rxd_rst[i] = (rxd_cnt_q[i] != '0);
    end
  end

  // ----------------------------------------------------------------
  // transmit fifo and serializer (lane 0 carries the data)
  // ----------------------------------------------------------------
  logic                  fifo_valid;
  logic                  fifo_ready;
  logic [DATA_W-1:0]     fifo_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic                  tx_in_valid;
  logic                  tx_run;
  logic                  bit_tick;
  logic [DATA_W-1:0]     tx_shift_q;
  logic [BIT_CNT_W-1:0]  tx_bits_q;
  logic                  tx_clk_q;
  logic                  tx_in_fifo_ready;

  // words on the direct input are ignored outside pma-direct mode
  assign tx_in_valid  = tx_valid_in && pma_direct && tx_en;
  assign tx_ready_out = tx_in_fifo_ready && pma_direct && tx_en;
  assign tx_run       = pma_direct && tx_en && pll_locked_out && !txa_rst[0] && !txd_rst[0];
  assign bit_tick     = use_ext_pll ? ext_rise : 1'b1;
  assign fifo_ready   = tx_run && bit_tick && tx_bits_q == '0;

  // lane 0 tx digital reset also flushes the fifo

  xcpc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clock_in      (clock_in),
    .rst_b_in      (rst_b_in && !txd_rst[0]),
    .in_valid_in   (tx_in_valid),
    .in_ready_out  (tx_in_fifo_ready),
    .in_data_in    (tx_pma_parallel_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_ready),
    .out_data_out  (fifo_data),
    .level_out     (fifo_level)
  );

  always_ff @(posedge clock_in) begin
    if (!rst_b_in || txa_rst[0] || txd_rst[0]) begin
      tx_shift_q <= '0;
      tx_bits_q  <= '0;
    end else if (tx_run && bit_tick) begin
      if (tx_bits_q == '0) begin
        if (fifo_valid) begin
          tx_shift_q <= fifo_data;
          tx_bits_q  <= BIT_CNT_W'(DATA_W - 1);
        end
      end else begin
        tx_shift_q <= {1'b0, tx_shift_q[DATA_W-1:1]};
        tx_bits_q  <= tx_bits_q - 1'b1;
      end
    end
  end

  assign tx_serial_out = tx_shift_q[0];

  // tx parallel clock toggles twice per word, held low outside pma-direct
  always_ff @(posedge clock_in) begin
    if (!rst_b_in || !pma_direct || txa_rst[0]) begin
      tx_clk_q <= 1'b0;
    end else if (tx_run && bit_tick &&
                 (tx_bits_q == '0 || tx_bits_q == BIT_CNT_W'(WORD_HALF))) begin
      tx_clk_q <= ~tx_clk_q;
    end
  end

  assign tx_pma_clkout_out = tx_clk_q;

  // ----------------------------------------------------------------
  // deserializer and recovered clocks
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]    rx_shift_q;
  logic [BIT_CNT_W-1:0] rx_bits_q;
  logic [DATA_W-1:0]    rx_word_q;
  logic                 rx_valid_q;
  logic [15:0]          rx_count_q;
  logic [LANES-1:0]     rx_clk_q;
  logic                 rx_run;

  assign rx_run = rx_en && !rxa_rst[0] && !rxd_rst[0];

  always_ff @(posedge clock_in) begin
    if (!rst_b_in || rxa_rst[0] || rxd_rst[0]) begin
      rx_shift_q <= '0;
      rx_bits_q  <= '0;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      if (rx_run) begin
        rx_shift_q <= {rx_bit, rx_shift_q[DATA_W-1:1]};
        if (rx_bits_q == BIT_CNT_W'(DATA_W - 1)) begin
          rx_bits_q  <= '0;
          rx_valid_q <= pma_direct;
        end else begin
          rx_bits_q <= rx_bits_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in || rxd_rst[0]) begin
      rx_word_q  <= '0;
      rx_count_q <= '0;
    end else if (rx_run && pma_direct && rx_bits_q == BIT_CNT_W'(DATA_W - 1)) begin
      rx_word_q  <= {rx_bit, rx_shift_q[DATA_W-1:1]};
      rx_count_q <= rx_count_q + 1'b1;
    end
  end

  assign rx_pma_parallel_data_out = rx_word_q;
  assign rx_valid_out             = rx_valid_q;

  // each lane's recovered clock follows its cdr reference while rx is enabled and the lane is out of rx analog reset
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      rx_clk_q <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (rxa_rst[i] || !rx_en) begin
          rx_clk_q[i] <= 1'b0;
        end else if (cdr_rise[i]) begin
          rx_clk_q[i] <= ~rx_clk_q[i];
        end
      end
    end
  end

  assign rx_pma_clkout_out = rx_clk_q;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [31:0] status;

  always_comb begin
    status = '0;
    status[STAT_PLL_LOCK_BIT]        = pll_locked_out;
    status[STAT_TXA_POS+:LANES]      = txa_rst;
    status[STAT_TXD_POS+:LANES]      = txd_rst;
    status[STAT_RXA_POS+:LANES]      = rxa_rst;
    status[STAT_RXD_POS+:LANES]      = rxd_rst;
    status[STAT_LEVEL_POS+:$clog2(FIFO_DEPTH)+1] = fifo_level;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= '0;
    end else if (reg_read_in) begin
      if (reg_addr_in == CTRL_OFFS) begin
        reg_rdata_out <= {{(32-CTRL_W){1'b0}}, ctrl_q};
      end else if (reg_addr_in == STATUS_OFFS) begin
        reg_rdata_out <= status;
      end else if (reg_addr_in == RXCNT_OFFS) begin
        reg_rdata_out <= {16'h0000, rx_count_q};
      end else begin
        reg_rdata_out <= '0;
      end
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule
`default_nettype wire

// File: tb/xcpc_line_model.sv
// serial medium and reference clock model facing the common port layer
`timescale 1ns/10ps
`default_nettype none
module xcpc_line_model
  import xcpc_pkg::*;
#(
  parameter logic [DATA_W-1:0] PAT = '0
) (
  input  wire logic        clock_in,
  output logic             tx_pll_refclk_out,
  output logic [LANES-1:0] rx_cdr_refclk_out,
  output logic             ext_pll_clk_out,
  output logic             rx_serial_out
);
  logic [6:0] bit_q = '0;
  logic [4:0] div_q = '0;

  always_ff @(posedge clock_in) begin
    div_q <= div_q + 5'h1;
    bit_q <= (bit_q == 7'(DATA_W - 1)) ? 7'h0 : bit_q + 7'h1;
  end

  // slow reference so a lost lock takes long enough to fill the fifo
  assign tx_pll_refclk_out = div_q[3];
  assign rx_cdr_refclk_out = {div_q[2], div_q[3], div_q[2], div_q[3]};
  assign ext_pll_clk_out   = div_q[1];
  // one word repeated, lsb first, with no gaps on the line
  assign rx_serial_out     = PAT[bit_q];
endmodule
`default_nettype wire

// File: tb/xcpc_common_properties.sv
// concurrent checks on the ports of the common port layer
`timescale 1ns/10ps
`default_nettype none
module xcpc_common_properties
  import xcpc_pkg::*;
(
  input wire logic              clock_in,
  input wire logic              rst_b_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0]       reg_wdata_in,
  input wire logic              reg_write_in,
  input wire logic              reg_read_in,
  input wire logic [31:0]       reg_rdata_out,
  input wire logic              pll_powerdown_in,
  input wire logic [LANES-1:0]  tx_analog_reset_in,
  input wire logic [LANES-1:0]  rx_analog_reset_in,
  input wire logic [LANES-1:0]  rx_digital_reset_in,
  input wire logic              tx_pma_clkout_out,
  input wire logic [LANES-1:0]  rx_pma_clkout_out,
  input wire logic              pll_locked_out,
  input wire logic              tx_ready_out,
  input wire logic [DATA_W-1:0] rx_pma_parallel_data_out,
  input wire logic              rx_valid_out,
  input wire logic              tx_serial_out
);
  // ----
  // shadow of the control register
  // ----
  logic [CTRL_W-1:0] ctrl_q;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_write_in && reg_addr_in == CTRL_OFFS) begin
      ctrl_q <= reg_wdata_in[CTRL_W-1:0];
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside the read answer cycle");
  a_ready_needs_mode: assert property (!ctrl_q[CTRL_PMA_DIRECT_BIT] |-> !tx_ready_out)
    else $error("tx ready outside pma-direct mode");
  a_txclk_mode: assert property ((!ctrl_q[CTRL_PMA_DIRECT_BIT]) [*2] |-> !tx_pma_clkout_out)
    else $error("tx parallel clock outside pma-direct mode");
  a_rxvalid_mode: assert property (rx_valid_out |-> ctrl_q[0] || $past(ctrl_q[0]))
    else $error("rx word delivered outside pma-direct mode");
  a_rxvalid_pulse: assert property (rx_valid_out |=> (!rx_valid_out) [*8])
    else $error("rx valid longer than one cycle");
  a_rxdata_change: assert property (
    $changed(rx_pma_parallel_data_out) && rx_pma_parallel_data_out != '0 |-> rx_valid_out)
    else $error("rx word changed without valid");
  a_pll_drop: assert property ($rose(pll_powerdown_in) |-> ##[2:6] (!pll_locked_out) [*8])
    else $error("pll lock held after power-down edge");
  a_txa_all: assert property ($rose(tx_analog_reset_in[0]) |->
    ##[2:6] (!tx_serial_out && !tx_pma_clkout_out) [*6])
    else $error("tx analog section not held in reset");
  a_rxa_lane: assert property ($rose(rx_analog_reset_in[1]) |->
    ##[2:6] (!rx_pma_clkout_out[1]) [*8])
    else $error("recovered clock runs during rx analog reset");
  a_rxd_lane: assert property ($rose(rx_digital_reset_in[0]) |->
    ##[2:6] (!rx_valid_out) [*8])
    else $error("rx word delivered during rx digital reset");
endmodule

bind xcpc_common xcpc_common_properties u_props (
  .clock_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
  .reg_rdata_out, .pll_powerdown_in, .tx_analog_reset_in, .rx_analog_reset_in,
  .rx_digital_reset_in, .tx_pma_clkout_out, .rx_pma_clkout_out, .pll_locked_out,
  .tx_ready_out, .rx_pma_parallel_data_out, .rx_valid_out, .tx_serial_out
);
`default_nettype wire

// File: tb/xcpc_common_tb_top.sv
// self-checking bench for the common port layer
`timescale 1ns/10ps
`default_nettype none
module xcpc_common_tb_top
  import xcpc_pkg::*;
;
  typedef struct {logic [ADDR_W-1:0] a; logic [31:0] w; logic [31:0] e;} xcpc_row_s;
  localparam logic [DATA_W-1:0] RX_PAT = 80'h0123_4567_89ab_cdef_5a3c;
  localparam logic [DATA_W-1:0] TX_W   = 80'hc3a5_0f1e_d2b4_9687_7801;

  logic              clock_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic [ADDR_W-1:0] reg_addr_in = '0;
  logic [31:0]       reg_wdata_in = '0;
  logic              reg_write_in = 1'b0;
  logic              reg_read_in = 1'b0;
  logic [31:0]       reg_rdata_out;
  logic              pll_powerdown_in = 1'b0;
  logic [15:0]       rv = '0;
  logic              tx_pll_refclk_in;
  logic [LANES-1:0]  rx_cdr_refclk_in;
  logic              ext_pll_clk_in;
  logic              tx_pma_clkout_out;
  logic [LANES-1:0]  rx_pma_clkout_out;
  logic              pll_locked_out;
  logic              tx_valid_in = 1'b0;
  logic              tx_ready_out;
  logic [DATA_W-1:0] tx_pma_parallel_data_in = '0;
  logic [DATA_W-1:0] rx_pma_parallel_data_out;
  logic              rx_valid_out;
  logic              tx_serial_out;
  logic              rx_serial_in;
  int                num_errors = 0;
  int                cmp_count = 0;
  xcpc_row_s         rows[4] = '{'{CTRL_OFFS, 32'hffff_ffff, 32'h0000_000f},
                                 '{4'hc, 32'h1234_5678, 32'h0},
                                 '{CTRL_OFFS, 32'h0000_0005, 32'h0000_0005},
                                 '{CTRL_OFFS, 32'h0, 32'h0}};

  always #(CLK_PERIOD_NS / 2) clock_in = ~clock_in;

  xcpc_common dut (
    .clock_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
    .reg_rdata_out, .pll_powerdown_in, .tx_analog_reset_in(rv[3:0]),
    .tx_digital_reset_in(rv[7:4]), .rx_analog_reset_in(rv[11:8]),
    .rx_digital_reset_in(rv[15:12]), .tx_pll_refclk_in, .rx_cdr_refclk_in,
    .ext_pll_clk_in, .tx_pma_clkout_out, .rx_pma_clkout_out, .pll_locked_out,
    .tx_valid_in, .tx_ready_out, .tx_pma_parallel_data_in, .rx_pma_parallel_data_out,
    .rx_valid_out, .tx_serial_out, .rx_serial_in
  );

  xcpc_line_model #(.PAT(RX_PAT)) u_line (
    .clock_in, .tx_pll_refclk_out(tx_pll_refclk_in), .rx_cdr_refclk_out(rx_cdr_refclk_in),
    .ext_pll_clk_out(ext_pll_clk_in), .rx_serial_out(rx_serial_in)
  );

  // ----
  // shared tasks
  // ----
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] w);
    reg_addr_in  <= a;
    reg_wdata_in <= w;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    @(negedge clock_in);
    d = reg_rdata_out;
    @(posedge clock_in);
  endtask

  // k selects lock (0) or a received word (1)
  task automatic wait_on(input int k, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge clock_in);
      if ((k == 0) ? (pll_locked_out === 1'b1) : (rx_valid_out === 1'b1)) break;
    end
    @(posedge clock_in);
    if (i == lim) begin
      chk(80'h0, 80'h1, "wait timed out");
      end_sim;
    end
  endtask

  function automatic logic is_rot(input logic [DATA_W-1:0] w);
    logic [2*DATA_W-1:0] d;
    is_rot = 1'b0;
    d = {RX_PAT, RX_PAT};
    for (int s = 0; s < DATA_W; s++) begin
      if (d[s +: DATA_W] === w) is_rot = 1'b1;
    end
  endfunction

  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0]       d;
    logic [DATA_W-1:0] b;
    logic [LANES-1:0]  tg;
    logic              p;
    int                n;
    repeat (12) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rd(CTRL_OFFS, d);
    chk(80'(d), 80'(CTRL_RESET), "ctrl reset value");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(80'(d), 80'(rows[i].e), "register readback");
    end
    tx_valid_in <= 1'b1;
    @(negedge clock_in);
    chk(80'(tx_ready_out), 80'h0, "ready outside pma-direct");
    @(posedge clock_in);
    tx_valid_in <= 1'b0;
    wr(CTRL_OFFS, 32'h0000_0007);
    wait_on(0, 400);
    tx_pma_parallel_data_in <= TX_W;
    tx_valid_in <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(negedge clock_in);
      p = tx_ready_out;
      @(posedge clock_in);
      if (p === 1'b1) break;
    end
    tx_valid_in <= 1'b0;
    chk(80'(p), 80'h1, "tx word taken");
    @(posedge clock_in);
    @(negedge clock_in);
    p = tx_pma_clkout_out;
    n = 0;
    for (int i = 0; i < DATA_W; i++) begin
      @(posedge clock_in);
      @(negedge clock_in);
      b[i] = tx_serial_out;
      n += int'(tx_pma_clkout_out !== p);
      p = tx_pma_clkout_out;
    end
    @(posedge clock_in);
    chk(b, TX_W, "serial word lsb first");
    chk(80'(n), 80'h2, "tx parallel clock edges per word");
    wait_on(1, 300);
    chk(80'(is_rot(rx_pma_parallel_data_out)), 80'h1, "rx word");
    rd(RXCNT_OFFS, d);
    chk(80'(d[31:16] == 16'h0 && d[15:0] != 16'h0), 80'h1, "rx word count");
    tg = '0;
    @(negedge clock_in);
    b[LANES-1:0] = rx_pma_clkout_out;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock_in);
      @(negedge clock_in);
      tg |= b[LANES-1:0] ^ rx_pma_clkout_out;
      b[LANES-1:0] = rx_pma_clkout_out;
    end
    @(posedge clock_in);
    chk(80'(tg), 80'hf, "recovered clocks run");
    pll_powerdown_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    chk(80'(pll_locked_out), 80'h0, "lock lost");
    @(posedge clock_in);
    tx_valid_in <= 1'b1;
    n = 0;
    for (int i = 0; i < 24; i++) begin
      @(negedge clock_in);
      n += int'(tx_ready_out === 1'b1);
      @(posedge clock_in);
      tx_pma_parallel_data_in <= 80'(i);
    end
    tx_valid_in <= 1'b0;
    chk(80'(n), 80'(FIFO_DEPTH + 1), "words taken until full");
    pll_powerdown_in <= 1'b0;
    rv <= 16'h0010;
    @(posedge clock_in);
    rv <= 16'h0;
    repeat (5) @(posedge clock_in);
    rd(STATUS_OFFS, d);
    chk(80'(d[24:20]), 80'h0, "fifo flushed");
    wait_on(0, 400);
    @(negedge clock_in);
    chk(80'(tx_ready_out), 80'h1, "ready after flush");
    @(posedge clock_in);
    for (int k = 0; k < 16; k++) begin
      rv <= 16'h1 << k;
      @(posedge clock_in);
      rv <= 16'h0;
      repeat (4) @(posedge clock_in);
      rd(STATUS_OFFS, d);
      chk(80'(d[19:4]), (k == 0) ? 80'hf : (k < 4) ? 80'h0 : 80'h1 << k, "reset scope");
      repeat (12) @(posedge clock_in);
    end
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rd(CTRL_OFFS, d);
    chk(80'(d), 80'(CTRL_RESET), "ctrl after second reset");
    end_sim;
  end
endmodule
`default_nettype wire
